// ---- hdl/ram_port_params.svh ----
`ifndef RAM_PORT_PARAMS_SVH
`define RAM_PORT_PARAMS_SVH

// register byte offsets
`define OFS_TARGET_SELECT 8'h24
`define OFS_COMMAND 8'h28
`define OFS_WORD_ADDRESS 8'h2C
`define OFS_WORD_VALUE 8'h30

// field positions
`define POS_DONE 31
`define POS_DIR 0
`define WIDTH_SEL 4
`define WIDTH_ADDR 14

// reset values
`define RST_SEL 4'h0
`define RST_DIR 1'h0
`define RST_ADDR 14'h0000
`define RST_DATA 32'h0000_0000

// ram access latency in cycles
`define RAM_LATENCY 2'h2

`endif

// ---- hdl/ram_port_pkg.sv ----
package ram_port_pkg;

    // ram targets
    typedef enum logic [3:0] {
        TGT_RX_BUF = 4'h0,
        TGT_HASH = 4'h1,
        TGT_OFFLOAD = 4'h2,
        TGT_RX_FIFO = 4'h3,
        TGT_TX_FIFO = 4'h4,
        TGT_DESC = 4'h5,
        TGT_TX_BUF = 4'h7
    } ram_target_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACCESS,
        ST_WAIT
    } port_state_t;

endpackage

// ---- hdl/ram_req_if.sv ----
`timescale 1ns/100ps
// request and reply between the access engine and the ram side
interface ram_req_if;
    logic req;
    logic wr;
    logic [3:0] sel;
    logic [13:0] addr;
    logic [31:0] wdata;
    logic ack;
    logic [31:0] rdata;

    modport engine (output req, output wr, output sel, output addr, output wdata, input ack, input rdata);
    modport ram (input req, input wr, input sel, input addr, input wdata, output ack, output rdata);
endinterface

// ---- hdl/ram_access_engine.sv ----
`timescale 1ns/100ps
`include "ram_port_params.svh"
// sequences one access: issues request, waits for ack, captures read data
module ram_access_engine (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic start_in,
    input wire logic wr_in,
    input wire logic [3:0] sel_in,
    input wire logic [13:0] addr_in,
    input wire logic [31:0] wdata_in,
    output logic busy_out,
    output logic done_out,
    output logic [31:0] rdata_out,
    ram_req_if.engine ram
);
    ram_port_pkg::port_state_t state_q;

    // state machine
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= ram_port_pkg::ST_IDLE;
            done_out <= 1'b0;
            rdata_out <= `RST_DATA;
        end else begin
            done_out <= 1'b0;
            case (state_q)
                ram_port_pkg::ST_IDLE: begin
                    if (start_in) begin
                        state_q <= ram_port_pkg::ST_ACCESS;
                    end
                end
                ram_port_pkg::ST_ACCESS: begin
                    state_q <= ram_port_pkg::ST_WAIT;
                end
                ram_port_pkg::ST_WAIT: begin
                    if (ram.ack) begin
                        state_q <= ram_port_pkg::ST_IDLE;
                        done_out <= 1'b1;
                        rdata_out <= ram.rdata;
                    end
                end
                default: begin
                    state_q <= ram_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // request fields latched at start
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ram.wr <= `RST_DIR;
            ram.sel <= `RST_SEL;
            ram.addr <= `RST_ADDR;
            ram.wdata <= `RST_DATA;
        end else if (start_in && state_q == ram_port_pkg::ST_IDLE) begin
            ram.wr <= wr_in;
            ram.sel <= sel_in;
            ram.addr <= addr_in;
            ram.wdata <= wdata_in;
        end
    end

    assign ram.req = (state_q == ram_port_pkg::ST_ACCESS);
    assign busy_out = (state_q != ram_port_pkg::ST_IDLE);
endmodule

// ---- hdl/ram_bank.sv ----
`timescale 1ns/100ps
`include "ram_port_params.svh"
// internal rams as flip-flop storage; reserved targets answer zero, drop writes
module ram_bank (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    ram_req_if.ram ram
);
    localparam int DEPTH = 16;
    logic [31:0] mem_q [0:7][0:DEPTH-1];
    logic [1:0] lat_q;
    logic [31:0] rdata_q;

    function automatic logic target_ok(input logic [3:0] s);
        target_ok = (s <= 4'h5) || (s == 4'h7);
    endfunction

    // storage, indexed by low address bits
    always_ff @(posedge mclk_in) begin
        if (ram.req && ram.wr && target_ok(ram.sel)) begin
            mem_q[ram.sel[2:0]][ram.addr[3:0]] <= ram.wdata;
        end
    end

    // fixed latency reply
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lat_q <= 2'h0;
            rdata_q <= `RST_DATA;
        end else if (ram.req) begin
            lat_q <= `RAM_LATENCY;
            rdata_q <= target_ok(ram.sel) ? mem_q[ram.sel[2:0]][ram.addr[3:0]] : 32'h0000_0000;
        end else if (lat_q != 2'h0) begin
            lat_q <= lat_q - 2'h1;
        end
    end

    assign ram.ack = (lat_q == 2'h1);
    assign ram.rdata = rdata_q;
endmodule

// ---- hdl/ram_data_port.sv ----
`timescale 1ns/100ps
`include "ram_port_params.svh"
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - done flag bit 31, ready reads one
// - read keeps flag low until data stored
// - four-bit select chooses target ram
// - a command write while idle starts one access
// - fourteen-bit word address, upper bits zero
// - data register sources writes, takes reads
module ram_data_port (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    ram_req_if ram_if ();

    logic [3:0] sel_q;
    logic dir_q;
    logic [13:0] addr_q;
    logic [31:0] data_q;
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic busy;
    logic done;
    logic [31:0] fetched;
    logic wr_fire;
    logic start;
    logic [31:0] addr_merged;

    // byte-lane merge, used for the address and data registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = r;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `OFS_TARGET_SELECT) || (a == `OFS_COMMAND) ||
                    (a == `OFS_WORD_ADDRESS) || (a == `OFS_WORD_VALUE);
    endfunction

    //////////////////////////////////////////////////////////////////////////////
    // write address and data capture, either order
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            aw_have_q <= 1'b0;
            aw_q <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_q <= {s_axi_awaddr[7:2], 2'b00};
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            w_have_q <= 1'b0;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    // a command write while idle starts one access; busy ones are dropped
    assign start = wr_fire && (aw_q == `OFS_COMMAND) && ws_q[0] && !busy;

    // write response
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(aw_q) ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // select register: writes ignored while busy
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sel_q <= `RST_SEL;
        end else if (wr_fire && !busy && aw_q == `OFS_TARGET_SELECT && ws_q[0]) begin
            sel_q <= wd_q[3:0];
        end
    end

    // command direction bit
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dir_q <= `RST_DIR;
        end else if (start) begin
            dir_q <= wd_q[`POS_DIR];
        end
    end

    // word address; merged word cut to the 14-bit field
    assign addr_merged = merge({18'h0, addr_q}, wd_q, ws_q);

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            addr_q <= `RST_ADDR;
        end else if (wr_fire && !busy && aw_q == `OFS_WORD_ADDRESS) begin
            addr_q <= addr_merged[13:0];
        end
    end

    // data register: host writes, or fetched word at read end
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            data_q <= `RST_DATA;
        end else if (done && !dir_q) begin
            data_q <= fetched;
        end else if (wr_fire && !busy && aw_q == `OFS_WORD_VALUE) begin
            data_q <= merge(data_q, wd_q, ws_q);
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // access engine and rams
    ram_access_engine u_engine (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .start_in(start),
        .wr_in(wd_q[`POS_DIR]),
        .sel_in(sel_q),
        .addr_in(addr_q),
        .wdata_in(data_q),
        .busy_out(busy),
        .done_out(done),
        .rdata_out(fetched),
        .ram(ram_if.engine)
    );

    ram_bank u_bank (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .ram(ram_if.ram)
    );

    //////////////////////////////////////////////////////////////////////////////
    // read channel; done flag low from start until data stored
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= is_mapped({s_axi_araddr[7:2], 2'b00}) ? 2'h0 : 2'h2;
                case ({s_axi_araddr[7:2], 2'b00})
                    // done pulse still pending means the fetched word is not yet stored
                    `OFS_TARGET_SELECT: s_axi_rdata <= {!busy && !done, 27'h0, sel_q};
                    `OFS_COMMAND: s_axi_rdata <= {31'h0, dir_q};
                    `OFS_WORD_ADDRESS: s_axi_rdata <= {18'h0, addr_q};
                    `OFS_WORD_VALUE: s_axi_rdata <= data_q;
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ---- tb/ram_data_port_chk.sv ----
`timescale 1ns/100ps
// bus-side checks of the data port registers
module ram_data_port_chk (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [31:0] wa_q, ra_q;
    logic any_wr_q;
    logic [3:0] idle_q;
    // last addresses, write history, cycles since a command write
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wa_q <= 32'h0;
            ra_q <= 32'h0;
            any_wr_q <= 1'b0;
            idle_q <= 4'hF;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
            if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
            if (s_axi_bvalid && s_axi_bready) any_wr_q <= 1'b1;
            if (s_axi_bvalid && s_axi_bready && wa_q == 32'h28) idle_q <= 4'h0;
            else if (idle_q != 4'hF) idle_q <= idle_q + 4'h1;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    reset_values_a: assert property (s_axi_rvalid && !any_wr_q |->
        s_axi_rdata == (ra_q == 32'h24 ? 32'h8000_0000 : 32'h0)) else $error("reset value wrong");
    sel_upper_a: assert property (s_axi_rvalid && ra_q == 32'h24 |-> s_axi_rdata[30:4] == 27'h0)
        else $error("select upper bits set");
    cmd_upper_a: assert property (s_axi_rvalid && ra_q == 32'h28 |-> s_axi_rdata[31:1] == 31'h0)
        else $error("command upper bits set");
    addr_upper_a: assert property (s_axi_rvalid && ra_q == 32'h2C |-> s_axi_rdata[31:14] == 18'h0)
        else $error("address upper bits set");
    ready_return_a: assert property (s_axi_rvalid && ra_q == 32'h24 && idle_q == 4'hF |-> s_axi_rdata[31])
        else $error("port stays busy");
    busy_cause_a: assert property (s_axi_rvalid && ra_q == 32'h24 && !s_axi_rdata[31] |-> idle_q != 4'hF)
        else $error("busy without command");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    cover property (s_axi_bvalid && s_axi_bready && wa_q == 32'h28);
    cover property (s_axi_rvalid && ra_q == 32'h24 && !s_axi_rdata[31]);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind ram_data_port ram_data_port_chk chk_u (.mclk_in, .reset_n_in, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ---- tb/ram_data_port_tb_top.sv ----
`timescale 1ns/100ps
module ram_data_port_tb_top;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, got, rnd_q = 32'h2A;
    logic [31:0] mem [0:15];
    logic [31:0] adr [0:15];
    int errors = 0, n_tests = 0, cycles = 0;
    always #10 mclk_in = ~mclk_in;
    ram_data_port dut_u (.mclk_in, .reset_n_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    //////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // reserved codes read zero and drop writes
    function automatic logic [31:0] exp_mem(input int t, input logic [31:0] d);
        return (t == 6 || t > 7) ? 32'h0 : d;
    endfunction
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one bus write, address and data offered together
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge mclk_in);
            if (s_axi_awready) aw_ok = 1'b1;
            if (s_axi_wready) w_ok = 1'b1;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        s_axi_bready <= 1'b1;
        do @(posedge mclk_in); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge mclk_in); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge mclk_in); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        got = s_axi_rdata;
        resp = s_axi_rresp;
    endtask
    // set up select, address, data, then start and poll for ready
    task automatic access(input int t, input logic dir);
        wr(32'h24, {adr[t][31:4], 4'(t)});
        wr(32'h2C, adr[t]);
        wr(32'h30, dir ? mem[t] : ~mem[t]);
        wr(32'h28, {31'h0, dir});
        for (int i = 0; i < 40; i++) begin
            rd(32'h24);
            if (got[31] === 1'b1) break;
        end
        check({31'h0, got[31]}, 32'h1);
    endtask
    // cut a hung run short
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        repeat (8) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        @(posedge mclk_in);
        rd(32'h24);
        check(got, 32'h8000_0000);
        rd(32'h28);
        check(got, 32'h0);
        rd(32'h2C);
        check(got, 32'h0);
        rd(32'h30);
        check(got, 32'h0);
        rd(32'h40);
        check({30'h0, resp}, 32'h2);
        // every target code written with random words, all-ones address as a corner
        // the port is exercised with the rest of the device stopped, so all targets are fair game
        for (int t = 0; t < 16; t++) begin
            rnd_q = lfsr(rnd_q);
            adr[t] = (t == 1) ? 32'hFFFF_FFFF : rnd_q;
            rnd_q = lfsr(rnd_q);
            mem[t] = rnd_q;
            access(t, 1'b1);
            check(got, 32'h8000_0000 | 32'(t));
            rd(32'h2C);
            check(got, adr[t] & 32'h3FFF);
            rd(32'h28);
            check(got, 32'h1);
        end
        // read back each word through the data register
        for (int t = 0; t < 16; t++) begin
            access(t, 1'b0);
            rd(32'h30);
            check(got, exp_mem(t, mem[t]));
            rd(32'h28);
            check(got, 32'h0);
        end
        close_out();
    end
endmodule
